/* File: common/async_rx_consts.svh */
// Constants of the asynchronous serial receiver
`ifndef ASYNC_RX_CONSTS_SVH
`define ASYNC_RX_CONSTS_SVH

`define RX_DATA_W          9
`define RX_FIFO_DEPTH      2
`define RX_FIFO_ENTRY_W    10
`define RX_LAST_PHASE      4'hF
`define RX_VOTE_FIRST      4'h7
`define RX_VOTE_MID        4'h8
`define RX_VOTE_LAST       4'h9
`define RX_BITS_EIGHT      4'h8
`define RX_BITS_NINE       4'h9
`define RX_PRESCALE_SLOW   2'h3
`define RX_PRESCALE_FAST   2'h0
`define RX_LINE_IDLE       1'b1
`define RX_DIVISOR_RESET   16'h0000
`define RX_DATA_RESET      9'h000

`endif

/* File: common/async_rx_pkg.sv */
// Types shared by the asynchronous serial receiver files
package async_rx_pkg;

  typedef struct packed {
    logic       frameErr;
    logic [8:0] data;
  } rx_char_t;

  typedef struct packed {
    logic continuousReceiveEnable;
    logic syncModeSelect;
    logic serialPortEnable;
    logic nineBitEnable;
  } rx_ctrl_t;

  typedef struct packed {
    logic        highSpeedRateSelect;
    logic        wideRateGeneratorSelect;
    logic [15:0] rateDivisorValue;
  } rx_rate_t;

  typedef struct packed {
    logic receiveInterruptEnable;
    logic peripheralInterruptEnable;
    logic globalInterruptEnable;
  } rx_irq_en_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_t;

endpackage

/* File: rtl/rx_char_fifo.sv */
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module rx_char_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  wire              push;
  wire              pop;
  wire  [PW-1:0]    wrNext;
  wire  [PW-1:0]    rdNext;

  assign inReady  = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign wrNext   = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
  assign rdNext   = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;

  // Storage words, each written only when the write pointer selects it
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem[i] <= '0;
      end else if (push && wrPtr == PW'(i)) begin
        mem[i] <= inData;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrNext;
      end
      if (pop) begin
        rdPtr <= rdNext;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule

/* File: rtl/async_serial_receiver.sv */
// Asynchronous serial receiver with oversampling, two-entry FIFO and flags
`timescale 1ns/1ps
`include "async_rx_consts.svh"
module async_serial_receiver (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Receive line
  input  wire logic                      receiveLinePin,
  // Control
  input  wire async_rx_pkg::rx_ctrl_t    ctrl,
  input  wire async_rx_pkg::rx_rate_t    rate,
  input  wire async_rx_pkg::rx_irq_en_t  irqEn,
  input  wire logic                      overrunClear,
  // Data read port
  input  wire logic                      readStrobe,
  output logic [8:0]                     receiveData,
  output logic                           readFrameError,
  // Status
  output logic                           receivePendingFlag,
  output logic                           headFrameError,
  output logic                           overrunError,
  output logic                           receiveBusy,
  output logic                           interruptRequest
);

  function automatic logic majority3(input logic a, input logic b,
                                     input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Line synchroniser and edge detection
  logic rxMeta;
  logic rxSync;
  logic rxPrev;
  wire  fallingEdge;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxMeta <= `RX_LINE_IDLE;
      rxSync <= `RX_LINE_IDLE;
      rxPrev <= `RX_LINE_IDLE;
    end else begin
      rxMeta <= receiveLinePin;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  assign fallingEdge = rxPrev & ~rxSync;

  // Receiver enable
  wire enabled;
  assign enabled = ctrl.continuousReceiveEnable & ~ctrl.syncModeSelect
                 & ctrl.serialPortEnable;

  // Rate generator: one tick per sixteenth of a bit
  logic [1:0]  prescale;
  logic [15:0] divCount;
  wire         slowRate;
  wire  [1:0]  prescaleTop;
  wire         prescaleDone;
  wire         divDone;
  wire         tick;

  assign slowRate     = ~rate.highSpeedRateSelect
                      & ~rate.wideRateGeneratorSelect;
  assign prescaleTop  = slowRate ? `RX_PRESCALE_SLOW : `RX_PRESCALE_FAST;
  assign prescaleDone = (prescale >= prescaleTop);
  assign divDone      = (divCount >= rate.rateDivisorValue);
  assign tick         = enabled & prescaleDone & divDone;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescale <= 2'h0;
    end else if (!enabled || prescaleDone) begin
      prescale <= 2'h0;
    end else begin
      prescale <= prescale + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= `RX_DIVISOR_RESET;
    end else if (!enabled || (prescaleDone && divDone)) begin
      divCount <= `RX_DIVISOR_RESET;
    end else if (prescaleDone) begin
      divCount <= divCount + 16'h0001;
    end
  end

  // Bit phase, votes and bit counter
  async_rx_pkg::rx_state_t state;
  async_rx_pkg::rx_state_t next_state;
  logic [3:0] phase;
  logic [1:0] votes;
  logic [3:0] bitIndex;
  logic [8:0] shiftReg;
  logic       stopFrameErr;
  wire        decide;
  wire        bitValue;
  wire        startEdge;
  wire  [3:0] bitsNeeded;
  wire        lastDataBit;

  assign startEdge   = enabled & fallingEdge & ~overrunError;
  assign decide      = tick & (phase == `RX_VOTE_LAST);
  assign bitValue    = majority3(votes[0], votes[1], rxSync);
  assign bitsNeeded  = ctrl.nineBitEnable ? `RX_BITS_NINE : `RX_BITS_EIGHT;
  assign lastDataBit = (bitIndex == bitsNeeded - 4'h1);

  // State and phase decodes
  wire inIdle;
  wire inStart;
  wire inData;
  wire inStop;
  wire atVoteFirst;
  wire atVoteMid;
  wire startOk;
  wire startBad;
  wire dataStep;

  assign inIdle      = (state == async_rx_pkg::ST_IDLE);
  assign inStart     = (state == async_rx_pkg::ST_START);
  assign inData      = (state == async_rx_pkg::ST_DATA);
  assign inStop      = (state == async_rx_pkg::ST_STOP);
  assign atVoteFirst = (phase == `RX_VOTE_FIRST);
  assign atVoteMid   = (phase == `RX_VOTE_MID);
  assign startOk     = inStart & decide & ~bitValue;
  assign startBad    = inStart & decide & bitValue;
  assign dataStep    = inData & decide;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
    end else if (inIdle) begin
      phase <= 4'h0;
    end else if (tick) begin
      phase <= phase + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      votes <= 2'h0;
    end else if (tick && (atVoteFirst || atVoteMid)) begin
      votes <= {votes[0], rxSync};
    end
  end

  // Receiver sequence
  always_comb begin
    next_state = state;
    case (state)
      async_rx_pkg::ST_IDLE: begin
        if (startEdge) begin
          next_state = async_rx_pkg::ST_START;
        end
      end
      async_rx_pkg::ST_START: begin
        if (startBad) begin
          next_state = async_rx_pkg::ST_IDLE;
        end else if (startOk) begin
          next_state = async_rx_pkg::ST_DATA;
        end
      end
      async_rx_pkg::ST_DATA: begin
        if (decide && lastDataBit) begin
          next_state = async_rx_pkg::ST_STOP;
        end
      end
      async_rx_pkg::ST_STOP: begin
        if (decide) begin
          next_state = async_rx_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = async_rx_pkg::ST_IDLE;
      end
    endcase
    if (!enabled) begin
      next_state = async_rx_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= async_rx_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Character shift register, one step per data bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitIndex <= 4'h0;
      shiftReg <= `RX_DATA_RESET;
    end else if (inStart) begin
      bitIndex <= 4'h0;
      shiftReg <= `RX_DATA_RESET;
    end else if (dataStep) begin
      bitIndex           <= bitIndex + 4'h1;
      shiftReg[bitIndex] <= bitValue;
    end
  end

  // Completed character towards the FIFO
  wire                     charDone;
  wire                     fifoInReady;
  wire                     fifoOutValid;
  async_rx_pkg::rx_char_t  newChar;
  async_rx_pkg::rx_char_t  headChar;
  wire                     pushChar;
  wire                     popChar;

  assign charDone = inStop & decide;
  assign stopFrameErr = ~bitValue;
  assign newChar.frameErr = stopFrameErr;
  assign newChar.data = shiftReg;
  assign pushChar = charDone & fifoInReady & ~overrunError;
  assign popChar  = readStrobe & fifoOutValid;

  rx_char_fifo #(
    .WIDTH (`RX_FIFO_ENTRY_W),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (pushChar),
    .inReady  (fifoInReady),
    .inData   (newChar),
    .outValid (fifoOutValid),
    .outReady (popChar),
    .outData  (headChar)
  );

  // Overrun: set wins over clear; dropping receive enable also clears
  wire overrunSet;
  wire overrunClr;
  assign overrunSet = charDone & ~fifoInReady;
  assign overrunClr = overrunClear | ~ctrl.continuousReceiveEnable;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrunError <= 1'b0;
    end else if (overrunSet) begin
      overrunError <= 1'b1;
    end else if (overrunClr) begin
      overrunError <= 1'b0;
    end
  end

  // Read port and status outputs
  wire pendingNow;
  assign pendingNow = enabled & fifoOutValid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receiveData    <= `RX_DATA_RESET;
      readFrameError <= 1'b0;
    end else if (popChar) begin
      receiveData    <= headChar.data;
      readFrameError <= headChar.frameErr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receivePendingFlag <= 1'b0;
      headFrameError     <= 1'b0;
      receiveBusy        <= 1'b0;
      interruptRequest   <= 1'b0;
    end else begin
      receivePendingFlag <= pendingNow;
      headFrameError     <= fifoOutValid & headChar.frameErr;
      receiveBusy        <= (next_state != async_rx_pkg::ST_IDLE);
      interruptRequest   <= pendingNow & irqEn.receiveInterruptEnable
                          & irqEn.peripheralInterruptEnable
                          & irqEn.globalInterruptEnable;
    end
  end

endmodule

/* File: testbench/serial_tx_model.sv */
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ps
module serial_tx_model (
  // Clock
  input  wire logic clk,
  // Serial line, idle high
  output logic      line
);
  int bitClk = 16;
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic stopLvl);
    hold(1'b0, bitClk);
    for (int i = 0; i < nb; i++) begin
      hold(d[i], bitClk);
    end
    hold(stopLvl, bitClk);
    line = 1'b1;
  endtask
endmodule

/* File: testbench/async_serial_receiver_asserts.sv */
// Port assertions of the asynchronous serial receiver
`timescale 1ns/1ps
module async_serial_receiver_asserts (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     resetn,
  // Inputs
  input wire logic                     receiveLinePin,
  input wire async_rx_pkg::rx_ctrl_t   ctrl,
  input wire async_rx_pkg::rx_irq_en_t irqEn,
  input wire logic                     overrunClear,
  input wire logic                     readStrobe,
  // Outputs
  input wire logic [8:0]               receiveData,
  input wire logic                     readFrameError,
  input wire logic                     receivePendingFlag,
  input wire logic                     headFrameError,
  input wire logic                     overrunError,
  input wire logic                     receiveBusy,
  input wire logic                     interruptRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rxOn;
  assign rxOn = ctrl.continuousReceiveEnable & ctrl.serialPortEnable
              & !ctrl.syncModeSelect;
  property p_irq_gate; interruptRequest |-> $past(&irqEn); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Irq unmasked");
  property p_pend_en; receivePendingFlag |-> $past(rxOn); endproperty
  a_pend_en: assert property (p_pend_en) else $error("Pend off");
  property p_head_fe;
    headFrameError && $past(rxOn) |-> receivePendingFlag; endproperty
  a_head_fe: assert property (p_head_fe) else $error("Head err");
  property p_ovr_hold; overrunError && !overrunClear
    && ctrl.continuousReceiveEnable |=> overrunError; endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("Ovr lost");
  property p_ovr_block;
    overrunError && $past(overrunError) |-> !$rose(receiveBusy); endproperty
  a_ovr_block: assert property (p_ovr_block) else $error("Ovr rx");
  property p_data_hold; !$past(readStrobe) |-> $stable(receiveData)
    && $stable(readFrameError); endproperty
  a_data_hold: assert property (p_data_hold) else $error("Data moved");
  property p_busy_start;
    $rose(receiveBusy) |-> !$past(receiveLinePin, 3); endproperty
  a_busy_start: assert property (p_busy_start) else $error("Bad start");
  property p_busy_min; $rose(receiveBusy) |=> receiveBusy[*7]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("Short start");
endmodule
bind async_serial_receiver async_serial_receiver_asserts
  u_async_serial_receiver_asserts (.clk(clk), .resetn(resetn),
  .receiveLinePin(receiveLinePin), .ctrl(ctrl), .irqEn(irqEn),
  .overrunClear(overrunClear), .readStrobe(readStrobe),
  .receiveData(receiveData), .readFrameError(readFrameError),
  .receivePendingFlag(receivePendingFlag), .headFrameError(headFrameError),
  .overrunError(overrunError), .receiveBusy(receiveBusy),
  .interruptRequest(interruptRequest));

/* File: testbench/tb_async_serial_receiver.sv */
// Self-checking testbench of the asynchronous serial receiver
`timescale 1ns/1ps
module tb_async_serial_receiver;
  logic                     clk = 1'b0;
  logic                     resetn = 1'b0;
  logic                     rxLine;
  async_rx_pkg::rx_ctrl_t   ctrl = 4'hA;
  async_rx_pkg::rx_rate_t   rate = 18'h20000;
  async_rx_pkg::rx_irq_en_t irqEn = 3'h0;
  logic                     overrunClear = 1'b0;
  logic                     readStrobe = 1'b0;
  logic [8:0]               receiveData;
  logic                     readFrameError, receivePendingFlag;
  logic                     headFrameError, overrunError;
  logic                     receiveBusy, interruptRequest;
  int                       error_cnt = 0;
  int                       checked = 0;
  logic [8:0]               c [4];
  always #5 clk = ~clk;
  serial_tx_model u_serial_tx_model (.clk(clk), .line(rxLine));
  async_serial_receiver u_async_serial_receiver (.clk(clk), .resetn(resetn),
    .receiveLinePin(rxLine), .ctrl(ctrl), .rate(rate), .irqEn(irqEn),
    .overrunClear(overrunClear), .readStrobe(readStrobe),
    .receiveData(receiveData), .readFrameError(readFrameError),
    .receivePendingFlag(receivePendingFlag),
    .headFrameError(headFrameError), .overrunError(overrunError),
    .receiveBusy(receiveBusy), .interruptRequest(interruptRequest));
  task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({8'h00, got}, {8'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [8:0] expc(input logic [8:0] d);
    return ctrl.nineBitEnable ? d : {1'b0, d[7:0]};
  endfunction
  task automatic tx(input logic [8:0] d, input logic stopLvl);
    u_serial_tx_model.send(d, ctrl.nineBitEnable ? 9 : 8, stopLvl);
    tick(2);
  endtask
  task automatic rdchk(input logic [8:0] e, input logic fe);
    readStrobe = 1'b1;
    tick(1);
    readStrobe = 1'b0;
    chk_data(receiveData, e);
    chk_bit(readFrameError, fe);
    tick(1);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end
  initial begin
    logic [8:0] d;
    void'($urandom(32'hAC3F));
    tick(10);
    resetn = 1'b1;
    tick(2);
    // Random characters, 8 and 9 bits, fast rate, then slow rate, then wide rate
    for (int i = 0; i < 12; i++) begin
      ctrl.nineBitEnable = i[0];
      if (i == 10) begin
        rate = 18'h00001;
        u_serial_tx_model.bitClk = 128;
      end
      if (i == 11) begin
        rate = 18'h10001;
        u_serial_tx_model.bitClk = 32;
      end
      d = 9'($urandom);
      tx(d, 1'b1);
      chk_bit(receivePendingFlag, 1'b1);
      chk_bit(headFrameError, 1'b0);
      rdchk(expc(d), 1'b0);
      chk_bit(receivePendingFlag, 1'b0);
    end
    rate = 18'h20000;
    u_serial_tx_model.bitClk = 16;
    ctrl.nineBitEnable = 1'b0;
    // Framing error, interrupt gating, receiver disabled
    d = 9'($urandom);
    tx(d, 1'b0);
    chk_bit(headFrameError, 1'b1);
    for (int k = 0; k < 8; k++) begin
      irqEn = k[2:0];
      tick(2);
      chk_bit(interruptRequest, k == 7);
      chk_bit(receivePendingFlag, 1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      ctrl = 4'hA ^ (4'h8 >> k);
      tick(2);
      chk_bit(receivePendingFlag, 1'b0);
      chk_bit(interruptRequest, 1'b0);
      tx(9'($urandom), 1'b1);
      ctrl = 4'hA;
      tick(2);
      chk_bit(receivePendingFlag, 1'b1);
    end
    rdchk(expc(d), 1'b1);
    chk_bit(headFrameError, 1'b0);
    chk_bit(receivePendingFlag, 1'b0);
    // Short low glitch on the line
    u_serial_tx_model.hold(1'b0, 4);
    chk_bit(receiveBusy, 1'b1);
    u_serial_tx_model.line = 1'b1;
    tick(40);
    chk_bit(receiveBusy, 1'b0);
    chk_bit(receivePendingFlag, 1'b0);
    // Two held, a third assembling, a fourth overruns
    for (int k = 0; k < 4; k++) begin
      c[k] = 9'($urandom);
    end
    tx(c[0], 1'b1);
    tx(c[1], 1'b1);
    fork
      tx(c[2], 1'b1);
      begin
        tick(80);
        rdchk(expc(c[0]), 1'b0);
      end
    join
    chk_bit(overrunError, 1'b0);
    tx(c[3], 1'b1);
    chk_bit(overrunError, 1'b1);
    tx(9'($urandom), 1'b1);
    rdchk(expc(c[1]), 1'b0);
    rdchk(expc(c[2]), 1'b0);
    chk_bit(receivePendingFlag, 1'b0);
    rdchk(expc(c[2]), 1'b0);
    overrunClear = 1'b1;
    tick(1);
    overrunClear = 1'b0;
    tick(1);
    chk_bit(overrunError, 1'b0);
    tx(d, 1'b1);
    rdchk(expc(d), 1'b0);
    end_sim();
  end
endmodule
